// >>> hsb_ctrl.v
// Purpose: connect/recovery controller of a hot-swap two-wire bus buffer
// Assumes: rst_n comes from supply undervoltage lockout; pins are open drain
// Notes: analog precharge and accelerators live outside; this drives enables
`timescale 1ns/10ps
`include "hsb_regs.vh"
module hsb_ctrl #(
  parameter IDLE_CYC = `HSB_IDLE_CYC, // idle qualifier length
  parameter STUCK_CYC = `HSB_STUCK_CYC, // stuck-low timeout
  parameter HALF_CYC = `HSB_HALF_CYC, // recovery half period
  parameter POR_CYC = `HSB_POR_CYC, // power-on settle time
  parameter PRE_CYC = `HSB_PRE_CYC // precharge start delay
) (
  input wire clk_sys, // 20 MHz system clock
  input wire rst_n, // synchronous reset (uvlo), active low
  input wire enable, // enable pin, high to run
  input wire backplane_data_i, // backplane data level
  output wire backplane_data_o, // backplane data drive value
  output wire backplane_data_oe, // backplane data pull low
  input wire backplane_clock_i, // backplane clock level
  output wire backplane_clock_o, // backplane clock drive value
  output wire backplane_clock_oe, // backplane clock pull low
  input wire card_data_i, // card data level
  output wire card_data_o, // card data drive value
  output wire card_data_oe, // card data pull low
  input wire card_clock_i, // card clock level
  output wire card_clock_o, // card clock drive value
  output wire card_clock_oe, // card clock pull low
  output wire ready_o, // ready drive value
  output wire ready_oe, // ready pulled low
  output reg precharge_q, // precharge bias enable
  output reg connected_q // sides joined
);
  localparam ST_POR = 3'd0; // settle after reset
  localparam ST_WAIT = 3'd1; // wait for idle or stop
  localparam ST_JOIN = 3'd2; // bus active
  localparam ST_RCLK = 3'd3; // recovery clocking
  localparam ST_RSTOP = 3'd4; // recovery stop generation
  localparam CW = 24; // timer width, holds 800000
  wire [4:0] s; // synchronised inputs
  wire bd, bc, cd, cc, en_s; // synchronised levels
  reg [2:0] st_q; // controller state
  reg [CW-1:0] tmr_q; // shared time base
  reg [CW-1:0] idle_q; // backplane high counter
  reg [CW-1:0] stuck_q; // card low counter
  reg [4:0] pulses_q; // recovery pulse count
  reg [1:0] phase_q; // recovery sub-step
  reg rclk_low_q; // recovery clock pull
  reg rdat_low_q; // recovery data pull
  reg bd_prev_q; // previous backplane data
  reg stop_seen_q; // stop qualifier latched
  reg pre_done_q; // precharge delay expired
  reg bp_drv_d_q, bp_drv_c_q, cd_drv_d_q, cd_drv_c_q; // bridge pulls
  reg [7:0] pull_hist_q; // bridge pulls one and two clocks back
  // ==========================================================
  // synchronise the enable and bus pins
  hsb_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({enable, backplane_data_i, backplane_clock_i, card_data_i, card_clock_i}),
    .sync_out(s)
  );
  assign en_s = s[4];
  assign bd = s[3];
  assign bc = s[2];
  assign cd = s[1];
  assign cc = s[0];
  // ==========================================================
  // ready pulled low while apart; the synchronised enable still drops it
  // within three clocks, well inside the allowed disable delay
  assign ready_oe = ~(connected_q & en_s);
  assign ready_o = 1'b0;
  // open-drain pulls: bridge when joined, recovery pulses on card side
  assign backplane_data_oe = bp_drv_d_q;
  assign backplane_clock_oe = bp_drv_c_q;
  assign card_data_oe = cd_drv_d_q | rdat_low_q;
  assign card_clock_oe = cd_drv_c_q | rclk_low_q;
  assign backplane_data_o = 1'b0;
  assign backplane_clock_o = 1'b0;
  assign card_data_o = 1'b0;
  assign card_clock_o = 1'b0;
  // ==========================================================
  // bridge: a side's low is passed only if the far side did not cause it,
  // which avoids the two pulls latching each other low; a released pull stays
  // masked two more clocks because the synchronised level lags by that much
  // (limitation: a genuine low arriving in that gap is passed two clocks late)
  always @(posedge clk_sys)
  begin
    if (!rst_n || !connected_q)
    begin
      bp_drv_d_q <= 1'b0;
      bp_drv_c_q <= 1'b0;
      cd_drv_d_q <= 1'b0;
      cd_drv_c_q <= 1'b0;
      pull_hist_q <= 8'h00;
    end
    else
    begin
      pull_hist_q <= {pull_hist_q[3:0], bp_drv_d_q, bp_drv_c_q, cd_drv_d_q, cd_drv_c_q};
      cd_drv_d_q <= ~bd & ~(bp_drv_d_q | pull_hist_q[3] | pull_hist_q[7]);
      cd_drv_c_q <= ~bc & ~(bp_drv_c_q | pull_hist_q[2] | pull_hist_q[6]);
      bp_drv_d_q <= ~cd & ~(cd_drv_d_q | pull_hist_q[1] | pull_hist_q[5]);
      bp_drv_c_q <= ~cc & ~(cd_drv_c_q | pull_hist_q[0] | pull_hist_q[4]);
    end
  end
  // ==========================================================
  // backplane idle and stop qualifiers, and card stuck-low timer
  always @(posedge clk_sys)
  begin
    if (!rst_n || !en_s)
    begin
      idle_q <= {CW{1'b0}};
      stuck_q <= {CW{1'b0}};
      bd_prev_q <= 1'b1;
      stop_seen_q <= 1'b0;
    end
    else
    begin
      bd_prev_q <= bd;
      if (bd && bc)
      begin
        if (idle_q != IDLE_CYC[CW-1:0])
          idle_q <= idle_q + 1'b1;
      end
      else
        idle_q <= {CW{1'b0}};
      // stop: data rises while clock high, only once settled
      if (st_q != ST_WAIT)
        stop_seen_q <= 1'b0;
      else if (bd && !bd_prev_q && bc)
        stop_seen_q <= 1'b1;
      else if (!bc)
        stop_seen_q <= 1'b0;
      if (st_q == ST_JOIN && (!cd || !cc))
      begin
        if (stuck_q != STUCK_CYC[CW-1:0])
          stuck_q <= stuck_q + 1'b1;
      end
      else
        stuck_q <= {CW{1'b0}};
    end
  end
  // ==========================================================
  // main controller with one shared time base
  always @(posedge clk_sys)
  begin
    if (!rst_n || !en_s)
    begin
      st_q <= ST_POR;
      tmr_q <= {CW{1'b0}};
      connected_q <= 1'b0;
      pulses_q <= 5'h00;
      phase_q <= 2'h0;
      rclk_low_q <= 1'b0;
      rdat_low_q <= 1'b0;
      precharge_q <= pre_done_q & rst_n; // precharge needs supply only
    end
    else
    begin
      case (st_q)
        ST_POR:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == POR_CYC[CW-1:0])
          begin
            st_q <= ST_WAIT;
            tmr_q <= {CW{1'b0}};
          end
          precharge_q <= precharge_q | pre_done_q;
        end
        ST_WAIT:
        begin
          precharge_q <= 1'b1;
          if ((idle_q == IDLE_CYC[CW-1:0] || stop_seen_q) && cd && cc)
          begin
            st_q <= ST_JOIN;
            connected_q <= 1'b1;
            precharge_q <= 1'b0;
          end
        end
        ST_JOIN:
        begin
          if (stuck_q == STUCK_CYC[CW-1:0])
          begin
            st_q <= ST_RCLK;
            connected_q <= 1'b0;
            tmr_q <= {CW{1'b0}};
            pulses_q <= 5'h00;
          end
        end
        ST_RCLK:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == HALF_CYC[CW-1:0])
          begin
            tmr_q <= {CW{1'b0}};
            if (!rclk_low_q && (cd || pulses_q == `HSB_MAX_PULSES))
            begin
              st_q <= ST_RSTOP;
              phase_q <= 2'h0;
              rdat_low_q <= 1'b1; // data and clock pulled low together
              rclk_low_q <= 1'b1;
            end
            else if (!rclk_low_q)
            begin
              rclk_low_q <= 1'b1;
              pulses_q <= pulses_q + 1'b1;
            end
            else
              rclk_low_q <= 1'b0;
          end
        end
        ST_RSTOP:
        begin
          tmr_q <= tmr_q + 1'b1;
          if (tmr_q == HALF_CYC[CW-1:0])
          begin
            tmr_q <= {CW{1'b0}};
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h0)
              rclk_low_q <= 1'b0; // clock rises with data low
            else if (phase_q == 2'h1)
              rdat_low_q <= 1'b0; // data rises: stop
            else
              st_q <= ST_WAIT;
          end
        end
        default:
          st_q <= ST_POR;
      endcase
    end
  end
  // ==========================================================
  // precharge delay counts from supply-valid, independent of enable
  reg [CW-1:0] pre_q; // precharge delay counter
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      pre_q <= {CW{1'b0}};
      pre_done_q <= 1'b0;
    end
    else if (!pre_done_q)
    begin
      pre_q <= pre_q + 1'b1;
      pre_done_q <= (pre_q == PRE_CYC[CW-1:0]);
    end
  end
endmodule // hsb_ctrl

// >>> hsb_ctrl_asserts.sv
// Purpose: port checks on the hot-swap control block
// Assumes: one clock domain, synchronous active-low reset
// Notes: shortened counts arrive through the bind
`timescale 1ns/10ps
module hsb_ctrl_chk #(
  parameter STUCK_CYC = 200, // stuck-low timeout
  parameter HALF_CYC = 10 // recovery half period
) (
  input wire clk_sys, // clock
  input wire rst_n, // reset
  input wire enable, // enable pin
  input wire backplane_data_i, // backplane data level
  input wire backplane_data_oe, // backplane data pull
  input wire card_data_i, // card data level
  input wire card_clock_i, // card clock level
  input wire card_data_oe, // card data pull
  input wire card_clock_oe, // card clock pull
  input wire ready_oe, // ready pull
  input wire precharge_q, // precharge on
  input wire connected_q // sides joined
);
  // ==========================================================
  // helper counters
  reg [31:0] low_q; // card low time while joined
  reg [4:0] pls_q; // recovery pulses since last join
  reg ck_q; // previous card clock pull
  // the stop step pulls data too, so it is not a pulse
  always @(posedge clk_sys)
  begin
    ck_q <= card_clock_oe;
    low_q <= (!rst_n || !connected_q || (card_data_i && card_clock_i)) ? 32'h0 : low_q + 32'h1;
    if (!rst_n || !enable || connected_q)
      pls_q <= 5'h0;
    else if (card_clock_oe && !ck_q && !card_data_oe && pls_q != 5'h1F)
      pls_q <= pls_q + 5'h1;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_card_low;
    (!card_data_i) [*4];
  endsequence
  sequence s_pulse_start;
    $rose(card_clock_oe) && !connected_q;
  endsequence
  property p_ready; ready_oe == !(connected_q && $past(enable, 2)); endproperty
  a_ready: assert property (p_ready) else $error("ready not tied to join");
  property p_join; s_card_low |=> !$rose(connected_q); endproperty
  a_join: assert property (p_join) else $error("joined with card low");
  property p_enoff; (!enable) [*4] |=> !connected_q; endproperty
  a_enoff: assert property (p_enoff) else $error("joined while disabled");
  property p_prech; $rose(connected_q) |-> $past(precharge_q); endproperty
  a_prech: assert property (p_prech) else $error("joined without precharge");
  property p_stuck; connected_q |-> low_q <= STUCK_CYC + 8; endproperty
  a_stuck: assert property (p_stuck) else $error("stuck card kept joined");
  property p_npulse; pls_q <= 5'h10; endproperty
  a_npulse: assert property (p_npulse) else $error("too many recovery pulses");
  property p_halfp; s_pulse_start |-> card_clock_oe [*6]; endproperty
  a_halfp: assert property (p_halfp) else $error("recovery pulse too short");
  property p_bridge;
    connected_q && $fell(backplane_data_i) && !backplane_data_oe |-> ##[1:4] card_data_oe;
  endproperty
  a_bridge: assert property (p_bridge) else $error("low not passed to card");
endmodule // hsb_ctrl_chk
bind hsb_ctrl hsb_ctrl_chk #(.STUCK_CYC(STUCK_CYC), .HALF_CYC(HALF_CYC)) chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .enable(enable), .backplane_data_i(backplane_data_i), .backplane_data_oe(backplane_data_oe),
  .card_data_i(card_data_i), .card_clock_i(card_clock_i), .card_data_oe(card_data_oe),
  .card_clock_oe(card_clock_oe), .ready_oe(ready_oe), .precharge_q(precharge_q), .connected_q(connected_q));

// >>> hsb_ctrl_test.sv
// Purpose: self-checking bench for the hot-swap control block
// Assumes: shortened timer parameters
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module hsb_ctrl_test;
  localparam int STK = 200; // shortened stuck timeout
  reg clk_sys = 1'b0; // 20 MHz clock
  reg rst_n = 1'b0; // reset
  reg enable = 1'b1; // enable pin
  reg bp_pull = 1'b0; // controller data pull
  reg link_run = 1'b0; // controller clocking
  reg card_hold = 1'b0; // target stuck data
  reg card_clk_pull = 1'b0; // target clock stretch
  wire bd, bc, cd, cc, bd_oe, bc_oe, cd_oe, cc_oe, ready_oe, precharge_q, connected_q;
  wire [4:0] pin_lvl; // open-drain drive values, all must stay low
  int err_total = 0; // mismatches
  int checks_done = 0; // comparisons
  always #25 clk_sys = ~clk_sys;
  hsb_ctrl #(.IDLE_CYC(20), .STUCK_CYC(STK), .HALF_CYC(10), .POR_CYC(10), .PRE_CYC(5)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .enable(enable), .backplane_data_i(bd), .backplane_data_o(pin_lvl[4]),
    .backplane_data_oe(bd_oe), .backplane_clock_i(bc), .backplane_clock_o(pin_lvl[3]),
    .backplane_clock_oe(bc_oe), .card_data_i(cd), .card_data_o(pin_lvl[2]), .card_data_oe(cd_oe),
    .card_clock_i(cc), .card_clock_o(pin_lvl[1]), .card_clock_oe(cc_oe), .ready_o(pin_lvl[0]),
    .ready_oe(ready_oe), .precharge_q(precharge_q), .connected_q(connected_q));
  hsb_far_model far_u (.bp_pull(bp_pull), .link_run(link_run), .card_hold(card_hold),
    .card_clk_pull(card_clk_pull), .bd_oe(bd_oe), .bc_oe(bc_oe), .cd_oe(cd_oe), .cc_oe(cc_oe),
    .bd(bd), .bc(bc), .cd(cd), .cc(cc));
  // ==========================================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for the join flag to reach a level
  task automatic wait_conn(input logic v, input int lim);
    int n;
    n = 0;
    while (connected_q !== v && n < lim)
    begin
      tick(1);
      n++;
    end
    chk(connected_q, v);
  endtask
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_insert; // card busy at power-up, then idle join
    card_hold = 1'b1;
    tick(60);
    chk(connected_q, 1'b0);
    chk(precharge_q, 1'b1);
    chk(ready_oe, 1'b1);
    card_hold = 1'b0;
    wait_conn(1'b1, 40);
    chk(ready_oe, 1'b0);
    chk({11'h000, pin_lvl}, 16'h0000);
  endtask
  task automatic t_pass; // lows cross both ways
    bp_pull = 1'b1;
    tick(3);
    chk(cd_oe, 1'b1);
    bp_pull = 1'b0;
    card_clk_pull = 1'b1;
    tick(3);
    chk(bc_oe, 1'b1);
    card_clk_pull = 1'b0;
    tick(4);
    chk(bc_oe, 1'b0);
  endtask
  task automatic t_off; // shutdown drops ready within three clocks
    enable = 1'b0;
    // enable passes a two-flop synchroniser, so look at 150 ns, three clocks on
    #150;
    chk(ready_oe, 1'b1);
    tick(4);
    chk(connected_q, 1'b0);
  endtask
  task automatic t_stop; // busy backplane, join on stop, well before idle
    bp_pull = 1'b1;
    link_run = 1'b1;
    tick(2);
    enable = 1'b1;
    tick(40);
    chk(connected_q, 1'b0);
    link_run = 1'b0;
    tick(12);
    bp_pull = 1'b0;
    wait_conn(1'b1, 12);
  endtask
  task automatic t_stuck; // target holds data through recovery, then lets go
    int n;
    logic p;
    card_hold = 1'b1;
    tick(STK - 10);
    chk(connected_q, 1'b1);
    chk(bd_oe, 1'b1);
    wait_conn(1'b0, 40);
    chk(ready_oe, 1'b1);
    n = 0;
    p = cc_oe;
    repeat (400)
    begin
      tick(1);
      if (cc_oe === 1'b1 && p === 1'b0 && cd_oe === 1'b0)
        n++;
      p = cc_oe;
    end
    chk(n[15:0], 16'h0010);
    card_hold = 1'b0;
    wait_conn(1'b1, 60);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    tick(6);
    rst_n = 1'b1;
    t_insert;
    t_pass;
    t_off;
    t_stop;
    t_stuck;
    wrap_up;
  end
  initial
  begin
    #(3000 * 50);
    err_total++;
    wrap_up;
  end
endmodule // hsb_ctrl_test

// >>> hsb_far_model.sv
// Purpose: backplane controller and card target facing the buffer
// Assumes: every bus line has a pull-up
// Notes: a released line floats to its pull-up level
`timescale 1ns/10ps
module hsb_far_model (
  input wire bp_pull, // controller holds data low
  input wire link_run, // controller clocks a frame
  input wire card_hold, // target stuck on data
  input wire card_clk_pull, // target stretches clock
  input wire bd_oe, // buffer pulls backplane data
  input wire bc_oe, // buffer pulls backplane clock
  input wire cd_oe, // buffer pulls card data
  input wire cc_oe, // buffer pulls card clock
  output wire bd, // backplane data wire
  output wire bc, // backplane clock wire
  output wire cd, // card data wire
  output wire cc // card clock wire
);
  // ==========================================================
  // link clock, parked high between frames
  reg link_q = 1'b1; // controller clock level
  // odd start offset keeps it out of phase with clk_sys
  initial
  begin
    #13;
    forever #200 link_q = link_run ? ~link_q : 1'b1;
  end
  // ==========================================================
  // wired-and of all parties on each line
  assign bd = !(bd_oe || bp_pull);
  assign bc = !(bc_oe || !link_q);
  assign cd = !(cd_oe || card_hold);
  assign cc = !(cc_oe || card_clk_pull);
endmodule // hsb_far_model

// >>> hsb_regs.vh
// Purpose: timing constants for the hot-swap bus buffer control logic
// Assumes: system clock of 20 MHz (50 ns period)
// Notes: times kept in their own unit, cycle counts derived from them
`ifndef HSB_REGS_VH
`define HSB_REGS_VH
// ==========================================================
// clock
`define HSB_CLK_NS 50
// ==========================================================
// timing figures in their own units
`define HSB_IDLE_US 95
`define HSB_STUCK_MS 40
`define HSB_RECOV_HALF_NS 58800
`define HSB_POR_READY_US 35
`define HSB_PRECHARGE_US 15
// ==========================================================
// derived cycle counts (integer division, all times round down)
`define HSB_IDLE_CYC ((`HSB_IDLE_US * 1000) / `HSB_CLK_NS)
`define HSB_STUCK_CYC ((`HSB_STUCK_MS * 1000000) / `HSB_CLK_NS)
`define HSB_HALF_CYC (`HSB_RECOV_HALF_NS / `HSB_CLK_NS)
`define HSB_POR_CYC ((`HSB_POR_READY_US * 1000) / `HSB_CLK_NS)
`define HSB_PRE_CYC ((`HSB_PRECHARGE_US * 1000) / `HSB_CLK_NS)
// ==========================================================
// recovery pulse budget
`define HSB_MAX_PULSES 16
`endif

// >>> hsb_sync.v
// Purpose: two-flop synchroniser for the asynchronous pin inputs
// Assumes: inputs come from outside the clk_sys domain
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module hsb_sync #(
  parameter W = 6
) (
  input wire clk_sys, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire [W-1:0] async_in, // raw pin levels
  output reg [W-1:0] sync_out // synchronised levels
);
  reg [W-1:0] meta_q; // first stage
  // ==========================================================
  // two stages; reset to released (high) bus levels
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // hsb_sync
